// ### ncocr_car_if.sv
`timescale 1ns/1ps
// carrier path between the register core, the wave generator and the mixer
interface ncocr_car_if;
  logic [15:0] phase;
  logic phase_vld;
  logic signed [15:0] cos_v;
  logic signed [15:0] sin_v;
  logic car_vld;
  logic signed [15:0] di;
  logic signed [15:0] dq;
  logic sideband;
  logic signed [15:0] mi;
  logic signed [15:0] mq;
  logic mix_vld;

  modport core (output phase, phase_vld, di, dq, sideband,
                input cos_v, sin_v, car_vld, mi, mq, mix_vld);
  modport wave (input phase, phase_vld, output cos_v, sin_v, car_vld);
  modport mix (input cos_v, sin_v, car_vld, di, dq, sideband,
               output mi, mq, mix_vld);
endinterface

// ### ncocr_mix.sv
`timescale 1ns/1ps
module ncocr_mix
  import ncocr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // carrier path
  ncocr_car_if.mix car
);

  typedef struct packed {
    logic vld;
    logic [15:0] mi;
    logic [15:0] mq;
  } ncocr_mix_type;

  ncocr_mix_type q_r;
  ncocr_mix_type q_nxt;
  logic signed [31:0] pic;
  logic signed [31:0] pqs;
  logic signed [31:0] pis;
  logic signed [31:0] pqc;
  logic signed [32:0] si;
  logic signed [32:0] sq;

  assign pic = car.di * car.cos_v;
  assign pqs = car.dq * car.sin_v;
  assign pis = car.di * car.sin_v;
  assign pqc = car.dq * car.cos_v;

  // high side rotates by +wt, low side by the conjugate carrier (inverted spectrum)
  always_comb begin
    q_nxt = q_r;
    q_nxt.vld = car.car_vld;
    if (car.sideband) begin
      si = 33'(pic) + 33'(pqs);
      sq = 33'(pqc) - 33'(pis);
    end else begin
      si = 33'(pic) - 33'(pqs);
      sq = 33'(pis) + 33'(pqc);
    end
    // half gain keeps the sum of two full products from overflowing
    if (car.car_vld) begin
      q_nxt.mi = si[31:16];
      q_nxt.mq = sq[31:16];
    end
  end

  // single register stage, the core counts on exactly one cycle here
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign car.mix_vld = q_r.vld;
  assign car.mi = q_r.mi;
  assign car.mq = q_r.mq;

endmodule // ncocr_mix

// ### ncocr_pkg.sv
package ncocr_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [6:0] ADDR_TUNE0 = 7'h54;
  localparam logic [6:0] ADDR_TUNE1 = 7'h55;
  localparam logic [6:0] ADDR_TUNE2 = 7'h56;
  localparam logic [6:0] ADDR_TUNE3 = 7'h57;
  localparam logic [6:0] ADDR_PHI = 7'h58;
  localparam logic [6:0] ADDR_PLO = 7'h59;
  localparam logic [6:0] ADDR_CTRL = 7'h5a;

  // ----------------------------------------
  // control register fields and reset values
  // ----------------------------------------
  localparam int CTRL_SIDEBAND = 0;
  localparam int CTRL_TUNE_REQ = 2;
  localparam int CTRL_TUNE_ACK = 3;
  localparam int CTRL_FRM_REQ = 4;
  localparam int CTRL_FRM_ACK = 5;
  localparam int CTRL_BYPASS = 7;
  localparam logic [7:0] CTRL_RESET = 8'h80;
  localparam logic [7:0] CTRL_RW_MASK = 8'h95;
  localparam logic [31:0] TUNE_RESET = 32'h0;
  localparam logic [15:0] PHASE_RESET = 16'h0;
  localparam logic [7:0] RDATA_NONE = 8'h00;

  // ----------------------------------------
  // timing: least length of an extended frame strobe
  // ----------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  localparam int FRAME_EXT_NS = 16;
  localparam logic [3:0] FRAME_EXT_CYC =
    4'((FRAME_EXT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

  // ----------------------------------------
  // carrier shape
  // ----------------------------------------
  localparam logic [15:0] QUARTER_TURN = 16'h4000;
  localparam logic [15:0] AMP_MAX = 16'h7fff;

  typedef enum logic [1:0] {
    FRM_IDLE = 2'b01,
    FRM_ARMED = 2'b10
  } ncocr_frm_type;

endpackage

// ### ncocr_regs.sv
// Function
// - the 32-bit tuning word sits in four byte registers, low byte at the lowest address.
// - writing a tuning byte changes only the shadow copy, never the running frequency.
// - the shadow word is loaded into the oscillator only on a 0 to 1 edge of the update request.
// - after that load the update acknowledge bit is set to 1.
// - a 16-bit two's complement phase offset, high byte first, becomes the phase at reset.
// - a 0 to 1 edge of the frame reset request resets the oscillator on the next extended strobe.
// - after that frame reset the frame reset acknowledge bit is set to 1.
// - sideband select 0 gives the high-side image, 1 the inverted low-side image.
`timescale 1ns/1ps
module ncocr_regs
  import ncocr_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // register port
  input wire logic [6:0] REG_ADDR,
  input wire logic REG_WR_EN,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_RD_EN,
  output logic [7:0] REG_RDATA,
  // frame strobe pin
  input wire logic FRAME_STROBE_IN,
  // sample stream
  input wire logic IN_VALID,
  input wire logic [15:0] IN_I,
  input wire logic [15:0] IN_Q,
  output logic OUT_VALID,
  output logic [15:0] OUT_I,
  output logic [15:0] OUT_Q
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [31:0] tune_sh;
    logic [31:0] tune_act;
    logic [15:0] phase_off;
    logic [15:0] off_act;
    logic [7:0] ctrl;
    logic [31:0] acc;
    logic frm_s1;
    logic frm_s2;
    logic [3:0] frm_cnt;
    ncocr_frm_type frm_st;
    logic [15:0] phase;
    logic s1_vld;
    logic [15:0] s1_i;
    logic [15:0] s1_q;
    logic [15:0] s2_i;
    logic [15:0] s2_q;
    logic [15:0] s3_i;
    logic [15:0] s3_q;
    logic [7:0] rdata;
    logic out_vld;
    logic [15:0] out_i;
    logic [15:0] out_q;
  } ncocr_state_type;

  ncocr_state_type q_r;
  ncocr_state_type q_nxt;
  logic wr_ctrl;
  logic tune_rise;
  logic frm_rise;
  logic ext_evt;
  logic frm_fire;

  ncocr_car_if car ();

  // ----------------------------------------
  // carrier generator and mixer
  // ----------------------------------------
  ncocr_wave u_wave (
    .clk(CLK),
    .rst_b(RST_B),
    .car(car.wave)
  );

  ncocr_mix u_mix (
    .clk(CLK),
    .rst_b(RST_B),
    .car(car.mix)
  );

  assign car.phase = q_r.phase;
  assign car.phase_vld = q_r.s1_vld;
  assign car.di = q_r.s2_i;
  assign car.dq = q_r.s2_q;
  assign car.sideband = q_r.ctrl[CTRL_SIDEBAND];

  // byte address hit on a write
  function automatic logic wr_hit(input logic [6:0] a);
    wr_hit = REG_WR_EN && REG_ADDR == a;
  endfunction

  // ----------------------------------------
  // request edges and extended strobe
  // ----------------------------------------
  // edges come from the write itself, so a steady 1 rewritten loads nothing
  // written out: a continuous assign would only wake on the function's constant argument
  assign wr_ctrl = REG_WR_EN && REG_ADDR == ADDR_CTRL;
  assign tune_rise = wr_ctrl && REG_WDATA[CTRL_TUNE_REQ] && !q_r.ctrl[CTRL_TUNE_REQ];
  assign frm_rise = wr_ctrl && REG_WDATA[CTRL_FRM_REQ] && !q_r.ctrl[CTRL_FRM_REQ];
  // fires once when the synced strobe has been high for the least length
  assign ext_evt = q_r.frm_s2 && q_r.frm_cnt == FRAME_EXT_CYC - 4'h1;
  assign frm_fire = q_r.frm_st == FRM_ARMED && ext_evt;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    q_nxt = q_r;
    // strobe pin synchroniser and length counter
    q_nxt.frm_s1 = FRAME_STROBE_IN;
    q_nxt.frm_s2 = q_r.frm_s1;
    if (!q_r.frm_s2) begin
      q_nxt.frm_cnt = 4'h0;
    end else if (q_r.frm_cnt != FRAME_EXT_CYC) begin
      q_nxt.frm_cnt = 4'(q_r.frm_cnt + 4'h1);
    end

    // register writes
    if (wr_hit(ADDR_TUNE0)) begin
      q_nxt.tune_sh[7:0] = REG_WDATA;
    end
    if (wr_hit(ADDR_TUNE1)) begin
      q_nxt.tune_sh[15:8] = REG_WDATA;
    end
    if (wr_hit(ADDR_TUNE2)) begin
      q_nxt.tune_sh[23:16] = REG_WDATA;
    end
    if (wr_hit(ADDR_TUNE3)) begin
      q_nxt.tune_sh[31:24] = REG_WDATA;
    end
    if (wr_hit(ADDR_PHI)) begin
      q_nxt.phase_off[15:8] = REG_WDATA;
    end
    if (wr_hit(ADDR_PLO)) begin
      q_nxt.phase_off[7:0] = REG_WDATA;
    end
    if (wr_ctrl) begin
      // only bypass, both requests and sideband are writable
      q_nxt.ctrl = (REG_WDATA & CTRL_RW_MASK) | (q_r.ctrl & ~CTRL_RW_MASK);
      // dropping a request clears its acknowledge
      if (!REG_WDATA[CTRL_TUNE_REQ]) begin
        q_nxt.ctrl[CTRL_TUNE_ACK] = 1'b0;
      end
      if (!REG_WDATA[CTRL_FRM_REQ]) begin
        q_nxt.ctrl[CTRL_FRM_ACK] = 1'b0;
      end
    end

    // tuning update; the set is placed after the clear so it wins
    if (tune_rise) begin
      q_nxt.tune_act = q_r.tune_sh;
      q_nxt.ctrl[CTRL_TUNE_ACK] = 1'b1;
    end

    // accumulator steps once per sample, phase taken before the step
    q_nxt.s1_vld = IN_VALID;
    if (IN_VALID) begin
      q_nxt.phase = 16'(q_r.acc[31:16] + q_r.off_act);
      q_nxt.acc = 32'(q_r.acc + q_r.tune_act);
      q_nxt.s1_i = IN_I;
      q_nxt.s1_q = IN_Q;
    end

    // frame reset arm and fire
    unique case (q_r.frm_st)
      FRM_IDLE: begin
        if (frm_rise) begin
          q_nxt.frm_st = FRM_ARMED;
        end
      end
      FRM_ARMED: begin
        if (ext_evt) begin
          q_nxt.acc = 32'h0;
          q_nxt.off_act = q_r.phase_off;
          // set after the write decode so it beats a same-cycle clear
          q_nxt.ctrl[CTRL_FRM_ACK] = 1'b1;
          q_nxt.frm_st = FRM_IDLE;
        end
      end
      default: begin
        q_nxt.frm_st = FRM_IDLE;
      end
    endcase

    // sample delay line matching the carrier pipeline
    if (q_r.s1_vld) begin
      q_nxt.s2_i = q_r.s1_i;
      q_nxt.s2_q = q_r.s1_q;
    end
    if (car.car_vld) begin
      q_nxt.s3_i = q_r.s2_i;
      q_nxt.s3_q = q_r.s2_q;
    end

    // output select; both paths share one latency so bypass switches cleanly
    q_nxt.out_vld = car.mix_vld;
    if (car.mix_vld) begin
      if (q_r.ctrl[CTRL_BYPASS]) begin
        q_nxt.out_i = q_r.s3_i;
        q_nxt.out_q = q_r.s3_q;
      end else begin
        q_nxt.out_i = car.mi;
        q_nxt.out_q = car.mq;
      end
    end

    // register read, held until the next read
    if (REG_RD_EN) begin
      unique case (REG_ADDR)
        ADDR_TUNE0: q_nxt.rdata = q_r.tune_sh[7:0];
        ADDR_TUNE1: q_nxt.rdata = q_r.tune_sh[15:8];
        ADDR_TUNE2: q_nxt.rdata = q_r.tune_sh[23:16];
        ADDR_TUNE3: q_nxt.rdata = q_r.tune_sh[31:24];
        ADDR_PHI: q_nxt.rdata = q_r.phase_off[15:8];
        ADDR_PLO: q_nxt.rdata = q_r.phase_off[7:0];
        // acknowledges read back live so software can poll them
        ADDR_CTRL: q_nxt.rdata = q_r.ctrl;
        default: q_nxt.rdata = RDATA_NONE;
      endcase
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      q_r <= '0;
      q_r.tune_sh <= TUNE_RESET;
      q_r.tune_act <= TUNE_RESET;
      q_r.phase_off <= PHASE_RESET;
      q_r.off_act <= PHASE_RESET;
      q_r.ctrl <= CTRL_RESET;
      q_r.frm_st <= FRM_IDLE;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign REG_RDATA = q_r.rdata;
  assign OUT_VALID = q_r.out_vld;
  assign OUT_I = q_r.out_i;
  assign OUT_Q = q_r.out_q;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_B);

  // checks sit on the register copies, so a later pipeline stage cannot mask a bad load
  AST_TUNE_MSB: assert property (
    REG_WR_EN && REG_ADDR == ADDR_TUNE3 |=> q_r.tune_sh[31:24] == $past(REG_WDATA))
    else $error("top tuning byte not in word bits 31 to 24");
  AST_SHADOW_ONLY: assert property (
    !tune_rise |=> q_r.tune_act == $past(q_r.tune_act))
    else $error("active tuning word moved without update edge");
  AST_TUNE_LOAD: assert property (
    tune_rise |=> q_r.tune_act == $past(q_r.tune_sh))
    else $error("shadow word not loaded on update edge");
  AST_TUNE_ACK: assert property (
    tune_rise |=> q_r.ctrl[CTRL_TUNE_ACK] ##1 q_r.ctrl[CTRL_TUNE_ACK] || $past(wr_ctrl))
    else $error("tuning acknowledge not set after load");
  AST_PHASE_LOAD: assert property (
    frm_fire |=> q_r.off_act == $past(q_r.phase_off) && q_r.acc == 32'h0)
    else $error("phase offset not applied at oscillator reset");
  AST_EXT_LEN: assert property (
    ext_evt |-> $past(q_r.frm_s2, 3) && $past(q_r.frm_s2, 1))
    else $error("strobe treated as extended too early");
  AST_FRAME_ACK: assert property (
    frm_fire |=> q_r.ctrl[CTRL_FRM_ACK] && q_r.frm_st == FRM_IDLE)
    else $error("frame reset acknowledge missing");
  AST_BYPASS: assert property (
    car.mix_vld && q_r.ctrl[CTRL_BYPASS] |=> OUT_VALID && OUT_I == $past(q_r.s3_i)
      && OUT_Q == $past(q_r.s3_q))
    else $error("bypass output differs from input sample");
  AST_ACC_STEP: assert property (
    IN_VALID && !frm_fire |=> q_r.acc == 32'($past(q_r.acc) + $past(q_r.tune_act)))
    else $error("accumulator did not step by tuning word");
  AST_ACC_HOLD: assert property (
    !IN_VALID && !frm_fire |=> q_r.acc == $past(q_r.acc))
    else $error("accumulator moved without a sample or a frame reset");
  AST_FRM_ARM: assert property (
    frm_rise && q_r.frm_st == FRM_IDLE |=> q_r.frm_st == FRM_ARMED)
    else $error("frame reset request edge did not arm the strobe watch");

  // covers for the main scenarios; the frame one spans a short strobe before the long one
  COV_TUNE: cover property (tune_rise ##1 q_r.ctrl[CTRL_TUNE_ACK]);
  COV_FRAME: cover property (frm_rise ##[1:40] frm_fire);
  COV_REQ_HELD: cover property (wr_ctrl && REG_WDATA[CTRL_TUNE_REQ] && q_r.ctrl[CTRL_TUNE_REQ]);
  COV_MOD_LOW: cover property (OUT_VALID && !q_r.ctrl[CTRL_BYPASS] && q_r.ctrl[CTRL_SIDEBAND]);
  COV_MOD_HIGH: cover property (OUT_VALID && !q_r.ctrl[CTRL_BYPASS] && !q_r.ctrl[CTRL_SIDEBAND]);

endmodule // ncocr_regs

// ### ncocr_regs_tb_top.sv
`timescale 1ns/1ps
module ncocr_regs_tb_top
  import ncocr_pkg::*;
;
  // ----------------------------------------
  // clock, reset and design ports
  // ----------------------------------------
  logic CLK = 1'b0;
  logic RST_B = 1'b0;
  logic [6:0] REG_ADDR = 7'h00;
  logic REG_WR_EN = 1'b0;
  logic [7:0] REG_WDATA = 8'h00;
  logic REG_RD_EN = 1'b0;
  logic [7:0] REG_RDATA;
  logic FRAME_STROBE_IN = 1'b0;
  logic IN_VALID = 1'b0;
  logic [15:0] IN_I = 16'h0000;
  logic [15:0] IN_Q = 16'h0000;
  logic OUT_VALID;
  logic [15:0] OUT_I;
  logic [15:0] OUT_Q;
  int n_fail = 0;
  int num_checks = 0;
  logic signed [15:0] oi;
  logic signed [15:0] oq;
  logic signed [15:0] ref_i;
  logic signed [15:0] ref_q;

  // 250 MHz clock
  always begin
    #2 CLK = ~CLK;
  end

  ncocr_regs i_ncocr_regs (
    .CLK(CLK),
    .RST_B(RST_B),
    .REG_ADDR(REG_ADDR),
    .REG_WR_EN(REG_WR_EN),
    .REG_WDATA(REG_WDATA),
    .REG_RD_EN(REG_RD_EN),
    .REG_RDATA(REG_RDATA),
    .FRAME_STROBE_IN(FRAME_STROBE_IN),
    .IN_VALID(IN_VALID),
    .IN_I(IN_I),
    .IN_Q(IN_Q),
    .OUT_VALID(OUT_VALID),
    .OUT_I(OUT_I),
    .OUT_Q(OUT_Q)
  );

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input bit ok, input string msg);
    num_checks++;
    if (!ok) begin
      n_fail++;
      $display("FAIL at %0t ns: %s", $time, msg);
    end
  endtask

  // one byte write, strobe up for exactly one edge
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge CLK);
    #1;
    REG_ADDR = a;
    REG_WDATA = d;
    REG_WR_EN = 1'b1;
    @(posedge CLK);
    #1;
    REG_WR_EN = 1'b0;
  endtask

  // read data holds until the next read, so it is sampled one edge late
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    @(posedge CLK);
    #1;
    REG_ADDR = a;
    REG_RD_EN = 1'b1;
    @(posedge CLK);
    #1;
    REG_RD_EN = 1'b0;
    @(posedge CLK);
    #1;
    if (REG_RDATA !== exp) begin
      chk(1'b0, $sformatf("read %h gave %h not %h", a, REG_RDATA, exp));
    end else begin
      chk(1'b1, "");
    end
  endtask

  // one sample in, bounded wait for its output, fixed latency of four
  task automatic smp(input logic [15:0] i, input logic [15:0] q);
    int n;
    @(posedge CLK);
    #1;
    IN_I = i;
    IN_Q = q;
    IN_VALID = 1'b1;
    @(posedge CLK);
    #1;
    IN_VALID = 1'b0;
    n = 1;
    while (OUT_VALID !== 1'b1 && n < 8) begin
      @(posedge CLK);
      #1;
      n++;
    end
    chk(n == 4, "sample latency wrong");
    oi = OUT_I;
    oq = OUT_Q;
  endtask

  // strobe held high for a number of cycles
  task automatic strobe(input int cyc);
    @(posedge CLK);
    #1;
    FRAME_STROBE_IN = 1'b1;
    repeat (cyc) @(posedge CLK);
    #1;
    FRAME_STROBE_IN = 1'b0;
    repeat (8) @(posedge CLK);
  endtask

  task automatic summarize();
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge CLK);
    #1;
    RST_B = 1'b1;
    // reset values, unmapped places read zero
    for (int k = 0; k < 7; k++) begin
      rd(7'(ADDR_TUNE0 + k), (k == 6) ? 8'h80 : 8'h00);
    end
    rd(7'h5b, 8'h00);
    rd(7'h53, 8'h00);
    $display("test reset values done");
    // byte registers read back distinct values in place
    for (int k = 0; k < 6; k++) begin
      wr(7'(ADDR_TUNE0 + k), 8'(8'h11 * (k + 1)));
    end
    for (int k = 0; k < 6; k++) begin
      rd(7'(ADDR_TUNE0 + k), 8'(8'h11 * (k + 1)));
    end
    // the tuning ack bit and unused bits do not take a write
    wr(ADDR_CTRL, 8'h4a);
    rd(ADDR_CTRL, 8'h00);
    wr(ADDR_CTRL, 8'h80);
    for (int k = 0; k < 4; k++) begin
      wr(7'(ADDR_TUNE0 + k), 8'h00);
    end
    wr(ADDR_PHI, 8'h40);
    wr(ADDR_PLO, 8'h00);
    $display("test register access done");
    // bypass passes samples untouched
    smp(16'h1234, 16'habcd);
    chk(oi === 16'h1234 && oq === 16'habcd, "bypass altered sample");
    $display("test bypass done");
    // frame reset: short strobe ignored, extended one loads the offset
    wr(ADDR_CTRL, 8'h10);
    strobe(2);
    rd(ADDR_CTRL, 8'h10);
    strobe(12);
    rd(ADDR_CTRL, 8'h30);
    // quarter-turn offset: sine at its peak, cosine near zero
    smp(16'h4000, 16'h0000);
    chk(oq > 16'sh1000 && oi < 16'sh0800 && oi > -16'sh0800, "offset not applied");
    ref_i = oi;
    ref_q = oq;
    wr(ADDR_CTRL, 8'h11);
    smp(16'h4000, 16'h0000);
    chk(oq < -16'sh1000, "low side not inverted");
    wr(ADDR_CTRL, 8'h10);
    $display("test frame reset and sideband done");
    // shadow word of a quarter turn per sample, not yet active
    wr(ADDR_TUNE3, 8'h40);
    smp(16'h4000, 16'h0000);
    chk(oi === ref_i && oq === ref_q, "shadow write moved the carrier");
    wr(ADDR_CTRL, 8'h14);
    rd(ADDR_CTRL, 8'h3c);
    smp(16'h4000, 16'h0000);
    chk(oi === ref_i && oq === ref_q, "phase before first step wrong");
    smp(16'h4000, 16'h0000);
    chk(oi < -16'sh1000, "word not loaded on update");
    // steady request level must not load the new zero shadow
    wr(ADDR_TUNE3, 8'h00);
    wr(ADDR_CTRL, 8'h14);
    smp(16'h4000, 16'h0000);
    chk(oq < -16'sh1000, "three-quarter phase wrong");
    smp(16'h4000, 16'h0000);
    chk(oi > 16'sh1000, "steady request reloaded the word");
    wr(ADDR_CTRL, 8'h10);
    rd(ADDR_CTRL, 8'h30);
    $display("test tuning update done");
    summarize();
  end

  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #40000;
    n_fail++;
    $display("FAIL at %0t ns: watchdog expired", $time);
    summarize();
  end
endmodule // ncocr_regs_tb_top

// ### ncocr_wave.sv
`timescale 1ns/1ps
module ncocr_wave
  import ncocr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // carrier path
  ncocr_car_if.wave car
);

  typedef struct packed {
    logic vld;
    logic [15:0] cos_v;
    logic [15:0] sin_v;
  } ncocr_wave_type;

  ncocr_wave_type q_r;
  ncocr_wave_type q_nxt;

  // parabolic sine: 4x(1-x) per half turn, no table needed at this precision
  function automatic logic [15:0] para(input logic [15:0] p);
    logic [29:0] x;
    logic [29:0] y;
    logic [15:0] m;
    x = {15'h0, p[14:0]};
    y = 30'(x * (30'(QUARTER_TURN) * 30'h2 - x));
    m = (y[28:13] > AMP_MAX) ? AMP_MAX : y[28:13];
    para = p[15] ? 16'(-m) : m;
  endfunction

  // one cycle from phase to cosine and sine
  always_comb begin
    q_nxt = q_r;
    q_nxt.vld = car.phase_vld;
    if (car.phase_vld) begin
      q_nxt.sin_v = para(car.phase);
      q_nxt.cos_v = para(16'(car.phase + QUARTER_TURN));
    end
  end

  // single register stage, the core counts on exactly one cycle here
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign car.car_vld = q_r.vld;
  assign car.cos_v = q_r.cos_v;
  assign car.sin_v = q_r.sin_v;

  AST_WAVE_ZERO: assert property (@(posedge clk) disable iff (!rst_b)
    car.phase_vld && car.phase == 16'h0 |=> q_r.sin_v == 16'h0 && q_r.cos_v == AMP_MAX)
    else $error("carrier at zero phase is not cosine peak");

endmodule // ncocr_wave
